// >>> core/ubic_regs.sv
// Indexed bridge registers and FIFO strobe front end.
// Assumes commands on clk; FIFO and resume pins unclocked_fifo_mode;
// link_clk is the interface clock.
//
// What this block does
// [R1] Source bit picks FIFO clock
// [R2] Frequency bit picks 30 or 48 MHz
// [R3] Clock pin floats unless enabled
// [R4] Polarity bit inverts interface clock
// [R5] Sync mode: strobes are clock enables
// [R6] Unclocked_fifo_mode mode: strobes act as edges
// [R7] Standby stops the oscillator
// [R8] Master sets standby after suspend
// [R9] Bus traffic or resume pin wakes
// [R10] Shared pin: chip select or flag
// [R11] Detach bit floats D+ pull-up
// [R12] Indirect access via pointer and data
// [R13] Control buffer and byte count
// [R14] Request bytes read; write stalls
// [R15] Polarity register, top bits read-only
// [R16] Wait 35 us after length change
// [R17] Wait 85 us after commit write
// [R18] Configuration resets to C9
// [R19] Interrupt mask resets all enabled
`default_nettype none

module ubic_regs (
    // Clocks and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    // Command port
    input  wire logic        cmd_valid,
    input  wire ubic_pkg::ubic_cmd_type cmd,
    output logic             rsp_valid,
    output logic      [7:0]  rsp_rdata,
    // USB engine side
    input  wire logic [63:0] control_request_in,
    input  wire logic        control_request_new,
    input  wire logic        usb_bus_traffic,
    input  wire logic        data_toggle_state,
    output logic             control_stall,
    output logic      [7:0]  interrupt_enable_mask,
    output logic      [7:0]  data_toggle_control,
    // Clocking and power
    output logic             fifo_clock_internal,
    output logic             internal_clock_48,
    output logic             interface_clock_pin_o,
    output logic             interface_clock_pin_oe_n,
    output logic             oscillator_enable,
    output logic             pullup_enable,
    input  wire logic        resume_request_pin_n,
    // FIFO pins
    input  wire logic        fifo_read_strobe,
    input  wire logic        fifo_write_strobe,
    input  wire logic        packet_commit_strobe,
    input  wire logic        flag_select_pin_i,
    input  wire logic        flag_output_four_src,
    output logic             flag_select_pin_o,
    output logic             flag_select_pin_oe_n,
    output logic             slave_selected,
    output logic      [2:0]  fifo_event,
    output logic      [7:0]  fifo_pin_polarity
);
    import ubic_pkg::*;

    // ****************************************
    // Command decode
    // ****************************************
    ubic_cfg_type cfg_reg;
    logic [7:0]   int_mask_reg;
    logic [7:0]   count_reg;
    logic [7:0]   ptr_low_reg;
    logic [7:0]   ptr_high_reg;
    logic [7:0]   polarity_reg;
    logic [7:0]   toggle_reg;
    logic [CTRL_BUF_AW-1:0] buf_ptr_reg;
    logic [CTRL_REQ_AW-1:0] req_ptr_reg;

    wire logic        do_wr    = cmd_valid && cmd.write;
    wire logic        do_rd    = cmd_valid && !cmd.write;
    wire logic        hit_cfg  = cmd.index == IDX_IFACE_CFG;
    wire logic        hit_mask = cmd.index == IDX_INT_MASK;
    wire logic        hit_buf  = cmd.index == IDX_CTRL_BUF;
    wire logic        hit_req  = cmd.index == IDX_CTRL_REQ;
    wire logic        hit_cnt  = cmd.index == IDX_CTRL_COUNT;
    wire logic        hit_plo  = cmd.index == IDX_PTR_LOW;
    wire logic        hit_phi  = cmd.index == IDX_PTR_HIGH;
    wire logic        hit_dat  = cmd.index == IDX_PTR_DATA;
    wire logic [15:0] ind_addr = {ptr_high_reg, ptr_low_reg};
    wire logic        ind_pol  = ind_addr == ADDR_PIN_POLARITY;
    wire logic        ind_tog  = ind_addr == ADDR_TOGGLE_CTL;
    wire logic        wr_cfg   = do_wr && hit_cfg;
    wire logic        buf_acc  = cmd_valid && hit_buf;

    // ****************************************
    // Wake and standby
    // ****************************************
    logic [4:0] pins_s;
    wire logic  wake = usb_bus_traffic || !pins_s[4];

    // [R9] Wake beats a same-cycle standby write
    wire ubic_cfg_type cfg_wr = ubic_cfg_type'(cmd.wdata);
    ubic_cfg_type      cfg_next;
    always_comb begin
        cfg_next = wr_cfg ? cfg_wr : cfg_reg;
        if (wake) begin
            cfg_next.standby = 1'b0;
        end
    end

    // [R18] Configuration register with reset value
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_reg <= ubic_cfg_type'(CFG_RESET);
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ****************************************
    // Plain registers
    // ****************************************
    // [R19] Mask resets with every event enabled
    always_ff @(posedge clk) begin
        if (!rstn) begin
            int_mask_reg <= INT_MASK_RESET;
        end else if (do_wr && hit_mask) begin
            int_mask_reg <= cmd.wdata;
        end
    end

    // [R12] Pointer bytes and control byte count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ptr_low_reg  <= 8'h00;
            ptr_high_reg <= 8'h00;
            count_reg    <= 8'h00;
        end else begin
            if (do_wr && hit_plo) begin
                ptr_low_reg <= cmd.wdata;
            end
            if (do_wr && hit_phi) begin
                ptr_high_reg <= cmd.wdata;
            end
            if (do_wr && hit_cnt) begin
                count_reg <= cmd.wdata;
            end
        end
    end

    // [R15] Polarity register, top two bits stay zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            polarity_reg <= POLARITY_RESET;
            toggle_reg   <= TOGGLE_RESET;
        end else begin
            if (do_wr && hit_dat && ind_pol) begin
                polarity_reg <= cmd.wdata & POLARITY_RW_MASK;
            end
            if (do_wr && hit_dat && ind_tog) begin
                toggle_reg <= cmd.wdata & TOGGLE_RW_MASK;
            end
        end
    end

    // ****************************************
    // Control endpoint buffer and request bytes
    // ****************************************
    // [R13] Buffer pointer walks, count write restarts
    // [R14] New request restarts pointer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            buf_ptr_reg <= '0;
            req_ptr_reg <= '0;
        end else begin
            if (do_wr && hit_cnt) begin
                buf_ptr_reg <= '0;
            end else if (buf_acc) begin
                buf_ptr_reg <= buf_ptr_reg + 1'b1;
            end
            if (control_request_new) begin
                req_ptr_reg <= '0;
            end else if (do_rd && hit_req) begin
                req_ptr_reg <= req_ptr_reg + 1'b1;
            end
        end
    end

    logic [7:0] buf_rdata;
    ubic_mem #(
        .DEPTH (CTRL_BUF_DEPTH),
        .AW    (CTRL_BUF_AW)
    ) u_ctrl_buf (
        .clk   (clk),
        .we    (do_wr && hit_buf),
        .addr  (buf_ptr_reg),
        .wdata (cmd.wdata),
        .rdata (buf_rdata)
    );

    // ****************************************
    // Read path: two cycles, every index answers
    // ****************************************
    wire logic [7:0] req_byte = control_request_in[{req_ptr_reg, 3'b000} +: 8];
    wire logic [7:0] tog_read = {data_toggle_state, toggle_reg[6:0]};
    wire logic [7:0] ind_read = ind_pol ? polarity_reg : (ind_tog ? tog_read : 8'h00);
    wire logic [7:0] rd_early =
        hit_cfg  ? cfg_reg      :
        hit_mask ? int_mask_reg :
        hit_req  ? req_byte     :
        hit_cnt  ? count_reg    :
        hit_plo  ? ptr_low_reg  :
        hit_phi  ? ptr_high_reg :
        hit_dat  ? ind_read     : 8'h00;

    logic       stage_valid_reg;
    logic       stage_mem_reg;
    logic [7:0] stage_data_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage_valid_reg <= 1'b0;
            stage_mem_reg   <= 1'b0;
            stage_data_reg  <= 8'h00;
            rsp_valid       <= 1'b0;
            rsp_rdata       <= 8'h00;
        end else begin
            stage_valid_reg <= cmd_valid;
            stage_mem_reg   <= do_rd && hit_buf;
            stage_data_reg  <= do_rd ? rd_early : 8'h00;
            rsp_valid       <= stage_valid_reg;
            rsp_rdata       <= stage_mem_reg ? buf_rdata : stage_data_reg;
        end
    end

    // ****************************************
    // Clock, power and pin outputs
    // ****************************************
    // Divided clk stands in; real oscillator sits outside
    logic div_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_reg                  <= 1'b0;
            interface_clock_pin_o    <= 1'b0;
            interface_clock_pin_oe_n <= 1'b1;
            fifo_clock_internal      <= 1'b1;
            internal_clock_48        <= 1'b1;
            oscillator_enable        <= 1'b1;
            pullup_enable            <= 1'b0;
            flag_select_pin_o        <= 1'b0;
            flag_select_pin_oe_n     <= 1'b1;
            slave_selected           <= 1'b0;
        end else begin
            div_reg <= ~div_reg;
            // [R4] Inverted clock on the pin
            interface_clock_pin_o <= div_reg ^ cfg_reg.interface_clock_invert;
            // [R3] Pin driven only when enabled
            interface_clock_pin_oe_n <= ~cfg_reg.interface_clock_output_en;
            // [R1] Clock source select
            fifo_clock_internal <= cfg_reg.fifo_clock_source_sel;
            // [R2] Internal frequency select
            internal_clock_48 <= cfg_reg.internal_clock_freq_sel;
            // [R7] Standby stops the oscillator
            oscillator_enable <= ~cfg_reg.standby;
            // [R11] Pull-up follows detach bit
            pullup_enable <= ~cfg_reg.pullup_detach;
            // [R10] Shared pin function
            flag_select_pin_o    <= flag_output_four_src;
            flag_select_pin_oe_n <= ~cfg_reg.flag_or_select_pin_function;
            slave_selected       <= ~cfg_reg.flag_or_select_pin_function && !pins_s[3];
        end
    end

    logic       stall_reg;
    logic [7:0] tog_out_reg;

    assign control_stall         = stall_reg;
    assign interrupt_enable_mask = int_mask_reg;
    assign data_toggle_control   = tog_out_reg;
    assign fifo_pin_polarity     = polarity_reg;

    // [R14] Single write to the request index stalls
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stall_reg   <= 1'b0;
            tog_out_reg <= TOGGLE_RESET;
        end else begin
            stall_reg   <= do_wr && hit_req;
            tog_out_reg <= toggle_reg;
        end
    end

    // ****************************************
    // FIFO strobe front end
    // ****************************************
    // Strobe vector order is {commit, write, read}
    wire logic [2:0] strobe_pins = {packet_commit_strobe, fifo_write_strobe, fifo_read_strobe};
    wire logic [2:0] strobe_pol  = {polarity_reg[POL_COMMIT_BIT], polarity_reg[POL_WRITE_BIT],
                                    polarity_reg[POL_READ_BIT]};

    ubic_sync #(.W(5)) u_pin_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({resume_request_pin_n, flag_select_pin_i, strobe_pins}),
        .q    (pins_s)
    );

    // Link reset and settings are slow levels
    logic       link_rstn;
    logic [3:0] link_cfg;

    ubic_sync #(.W(1)) u_link_rst (
        .clk  (link_clk),
        .rstn (1'b1),
        .d    (rstn),
        .q    (link_rstn)
    );

    ubic_sync #(.W(4)) u_link_cfg (
        .clk  (link_clk),
        .rstn (link_rstn),
        .d    ({cfg_reg.unclocked_fifo_mode, strobe_pol}),
        .q    (link_cfg)
    );

    // [R5] Sampled enables become toggles
    logic [2:0]      link_tgl_reg;
    wire logic [2:0] link_act       = ~(strobe_pins ^ link_cfg[2:0]);
    wire logic [2:0] link_tgl_next  = link_tgl_reg ^ (link_cfg[3] ? 3'h0 : link_act);

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            link_tgl_reg <= 3'h0;
        end else begin
            link_tgl_reg <= link_tgl_next;
        end
    end

    logic [2:0] tgl_s;
    logic [2:0] tgl_prev_reg;
    logic [2:0] act_prev_reg;

    ubic_sync #(.W(3)) u_tgl_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (link_tgl_reg),
        .q    (tgl_s)
    );

    // [R6] Unclocked mode: active edge of each strobe is the event
    wire logic [2:0] act_s      = ~(pins_s[2:0] ^ strobe_pol);
    wire logic [2:0] unclocked_fifo_mode_edge = act_s & ~act_prev_reg;
    wire logic [2:0] sync_evt   = tgl_s ^ tgl_prev_reg;
    wire logic [2:0] event_next = cfg_reg.unclocked_fifo_mode ? unclocked_fifo_mode_edge : sync_evt;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tgl_prev_reg <= 3'h0;
            // Synced pins read 0 (active) out of reset: no false edge
            act_prev_reg <= 3'h7;
            fifo_event   <= 3'h0;
        end else begin
            tgl_prev_reg <= tgl_s;
            act_prev_reg <= act_s;
            fifo_event   <= event_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    cfg_reset_a: assert property (@(posedge clk) !rstn |=> cfg_reg == CFG_RESET) // [R18]
        else $error("cfg reset wrong");
    mask_reset_a: assert property (@(posedge clk) !rstn |=> int_mask_reg == 8'hFF) // [R19]
        else $error("mask reset wrong");
    clk_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
        $rose(cfg_reg.interface_clock_output_en) |=> !interface_clock_pin_oe_n)
        else $error("clock pin not driven");
    standby_osc_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
        wr_cfg && cfg_wr.standby && !wake |=> ##1 !oscillator_enable)
        else $error("oscillator not stopped");
    wake_osc_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
        !oscillator_enable && wake |-> ##2 oscillator_enable)
        else $error("no wake");
    detach_pull_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
        wr_cfg && !cfg_wr.pullup_detach |-> ##2 pullup_enable)
        else $error("pull-up not on");
    shared_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
        flag_select_pin_oe_n == !$past(cfg_reg.flag_or_select_pin_function)
        && !(slave_selected && !flag_select_pin_oe_n))
        else $error("shared pin wrong");
    polarity_top_a: assert property (@(posedge clk) disable iff (!rstn) // [R15]
        polarity_reg[7:6] == 2'b00)
        else $error("polarity top bits set");
    answer_time_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
        cmd_valid |-> ##2 rsp_valid)
        else $error("late answer");
    unclocked_evt_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
        cfg_reg.unclocked_fifo_mode && $past(cfg_reg.unclocked_fifo_mode)
        && act_s[0] && !act_prev_reg[0] |=> fifo_event[0])
        else $error("read edge lost");
endmodule

`default_nettype wire

// >>> pkg/ubic_pkg.sv
// Constants, field layouts and carriers for the bridge configuration block.
// Assumes the register block, master model and bench import it whole; sync and memory do not use it.
`default_nettype none

package ubic_pkg;

    // ****************************************
    // Command indices
    // ****************************************
    localparam logic [5:0] IDX_IFACE_CFG    = 6'h01;
    localparam logic [5:0] IDX_INT_MASK     = 6'h2E;
    localparam logic [5:0] IDX_ID_TABLE     = 6'h30;
    localparam logic [5:0] IDX_CTRL_BUF     = 6'h31;
    localparam logic [5:0] IDX_CTRL_REQ     = 6'h32;
    localparam logic [5:0] IDX_CTRL_COUNT   = 6'h33;
    localparam logic [5:0] IDX_PTR_LOW      = 6'h3A;
    localparam logic [5:0] IDX_PTR_HIGH     = 6'h3B;
    localparam logic [5:0] IDX_PTR_DATA     = 6'h3C;

    // ****************************************
    // Indirect addresses
    // ****************************************
    localparam logic [15:0] ADDR_PIN_POLARITY = 16'hE609;
    localparam logic [15:0] ADDR_TOGGLE_CTL   = 16'hE683;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] CFG_RESET        = 8'hC9;
    localparam logic [7:0] INT_MASK_RESET   = 8'hFF;
    localparam logic [7:0] POLARITY_RESET   = 8'h00;
    localparam logic [7:0] POLARITY_RW_MASK = 8'h3F;
    localparam logic [7:0] TOGGLE_RW_MASK   = 8'h7F;
    localparam logic [7:0] TOGGLE_RESET     = 8'h00;

    // ****************************************
    // Polarity bit positions
    // ****************************************
    localparam int POL_COMMIT_BIT = 5;
    localparam int POL_OE_BIT     = 4;
    localparam int POL_READ_BIT   = 3;
    localparam int POL_WRITE_BIT  = 2;
    localparam int POL_EMPTY_BIT  = 1;
    localparam int POL_FULL_BIT   = 0;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int CTRL_BUF_DEPTH = 64;
    localparam int CTRL_BUF_AW    = 6;
    localparam int CTRL_REQ_AW    = 3;

    // Interface configuration, bit 7 first
    typedef struct packed {
        logic fifo_clock_source_sel;
        logic internal_clock_freq_sel;
        logic interface_clock_output_en;
        logic interface_clock_invert;
        logic unclocked_fifo_mode;
        logic standby;
        logic flag_or_select_pin_function;
        logic pullup_detach;
    } ubic_cfg_type;

    // One command from the master's decoder
    typedef struct packed {
        logic       write;
        logic [5:0] index;
        logic [7:0] wdata;
    } ubic_cmd_type;

endpackage

`default_nettype wire

// >>> core/ubic_sync.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is a slow level or a toggle.
`default_nettype none

module ubic_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

`default_nettype wire

// >>> core/ubic_mem.sv
// Small single-port byte memory with registered read data.
// Assumes one access per cycle; contents are undefined after reset.
`default_nettype none

module ubic_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    // Clock
    input  wire logic          clk,
    // Access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem_array [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_array[addr] <= wdata;
        end
        rdata <= mem_array[addr];
    end
endmodule

`default_nettype wire

// >>> verification/ubic_master_model.sv
// External master model: indexed commands out, answers back.
// Assumes one answer per command within a few cycles.
`default_nettype none

module ubic_master_model (
    // Clock
    input  wire logic              clk,
    // Command port
    output logic                   cmd_valid,
    output ubic_pkg::ubic_cmd_type cmd,
    input  wire logic              rsp_valid,
    input  wire logic [7:0]        rsp_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import ubic_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{write: w, index: i, wdata: d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Released bus carries junk, never the last command
        cmd       <= ~cmd;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rsp_valid !== 1'b1 && n < 6);
        q = (rsp_valid === 1'b1) ? rsp_rdata : 8'hXX;
    endtask

    // Pointer low, pointer high, then data
    // No FIFO writes, so waits hold
    task automatic ind(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        xfer(1'b1, IDX_PTR_LOW, a[7:0], q);
        xfer(1'b1, IDX_PTR_HIGH, a[15:8], q);
        xfer(w, IDX_PTR_DATA, d, q);
    endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the bridge configuration registers.
// Assumes the master model owns the command port.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ubic_pkg::*;

    logic         clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, sel_drv = 1'b1;
    logic         control_request_new = 1'b0, usb_bus_traffic = 1'b0;
    logic         data_toggle_state = 1'b0, resume_request_pin_n = 1'b1;
    logic         flag_output_four_src = 1'b0, cmd_valid, rsp_valid, control_stall;
    logic         fifo_clock_internal, internal_clock_48, interface_clock_pin_o;
    logic         interface_clock_pin_oe_n, oscillator_enable, pullup_enable;
    logic         flag_select_pin_o, flag_select_pin_oe_n, slave_selected;
    logic [2:0]   stb = 3'h7, fifo_event;
    logic [63:0]  control_request_in = 64'h0;
    logic [7:0]   rsp_rdata, interrupt_enable_mask, data_toggle_control, fifo_pin_polarity, q;
    logic [7:0]   ev_cnt [3] = '{default: 8'h00};
    logic [7:0]   stall_cnt = 8'h00;
    ubic_cmd_type cmd;
    wire logic    flag_select_pin_i;
    int           error_cnt = 0, cmp_count = 0, cyc = 0;

    // Shared pin: design drives it while enable is low
    assign flag_select_pin_i = flag_select_pin_oe_n ? sel_drv : flag_select_pin_o;

    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #7;
        forever #7.5 link_clk = ~link_clk;
    end

    ubic_master_model mm (.clk, .cmd_valid, .cmd, .rsp_valid, .rsp_rdata);
    ubic_regs dut (
        .clk, .rstn, .link_clk, .cmd_valid, .cmd, .rsp_valid, .rsp_rdata,
        .control_request_in, .control_request_new, .usb_bus_traffic, .data_toggle_state,
        .control_stall, .interrupt_enable_mask, .data_toggle_control,
        .fifo_clock_internal, .internal_clock_48, .interface_clock_pin_o,
        .interface_clock_pin_oe_n, .oscillator_enable, .pullup_enable,
        .resume_request_pin_n, .fifo_read_strobe(stb[0]), .fifo_write_strobe(stb[1]),
        .packet_commit_strobe(stb[2]), .flag_select_pin_i, .flag_output_four_src,
        .flag_select_pin_o, .flag_select_pin_oe_n, .slave_selected, .fifo_event,
        .fifo_pin_polarity
    );

    // Pulse counters and hang limit
    always @(posedge clk) begin
        cyc++;
        stall_cnt <= stall_cnt + {7'h00, control_stall === 1'b1};
        for (int i = 0; i < 3; i++) begin
            ev_cnt[i] <= ev_cnt[i] + {7'h00, fifo_event[i] === 1'b1};
        end
        if (cyc == 6000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        mm.xfer(1'b0, IDX_IFACE_CFG, 8'h00, q);
        chk("cfg", CFG_RESET, q);
        mm.xfer(1'b0, IDX_INT_MASK, 8'h00, q);
        chk("mask", INT_MASK_RESET, q);
        chk1("src", 1'b1, fifo_clock_internal);
        chk1("f48", 1'b1, internal_clock_48);
        chk1("ckoe", 1'b1, interface_clock_pin_oe_n);
        chk1("pull", 1'b0, pullup_enable);
        mm.ind(1'b0, ADDR_PIN_POLARITY, 8'h00, q);
        chk("pol", POLARITY_RESET, q);
        $display("test reset done");
    endtask

    task automatic t_fifo;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) stb[i] <= 1'b0;
            repeat (3) @(posedge clk);
            stb[i] <= 1'b1;
            repeat (8) @(posedge clk);
        end
        #1;
        for (int i = 0; i < 3; i++) chk("ev", 8'h01, ev_cnt[i]);
        mm.xfer(1'b1, IDX_IFACE_CFG, 8'hC1, q);
        // One link edge sees the strobe active
        @(posedge link_clk) stb[0] <= 1'b0;
        @(posedge link_clk) stb[0] <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("evs", 8'h02, ev_cnt[0]);
        mm.xfer(1'b1, IDX_IFACE_CFG, CFG_RESET, q);
        $display("test fifo done");
    endtask

    task automatic t_cfg;
        mm.xfer(1'b1, IDX_IFACE_CFG, 8'h32, q);
        chk1("src", 1'b0, fifo_clock_internal);
        chk1("f48", 1'b0, internal_clock_48);
        chk1("ckoe", 1'b0, interface_clock_pin_oe_n);
        chk1("pull", 1'b1, pullup_enable);
        @(posedge clk) flag_output_four_src <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk1("fd", 1'b1, flag_select_pin_o);
        @(posedge clk) flag_output_four_src <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk1("sel", 1'b0, slave_selected);
        mm.xfer(1'b1, IDX_IFACE_CFG, CFG_RESET, q);
        @(posedge clk) sel_drv <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk1("sel", 1'b1, slave_selected);
        @(posedge clk) sel_drv <= 1'b1;
        $display("test config done");
    endtask

    task automatic t_standby;
        mm.xfer(1'b1, IDX_IFACE_CFG, 8'hCD, q);
        chk1("osc", 1'b0, oscillator_enable);
        @(posedge clk) resume_request_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        resume_request_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk1("osc", 1'b1, oscillator_enable);
        mm.xfer(1'b0, IDX_IFACE_CFG, 8'h00, q);
        chk("cfg", CFG_RESET, q);
        mm.xfer(1'b1, IDX_IFACE_CFG, 8'hCD, q);
        @(posedge clk) usb_bus_traffic <= 1'b1;
        @(posedge clk) usb_bus_traffic <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk1("osc", 1'b1, oscillator_enable);
        $display("test standby done");
    endtask

    task automatic t_ind;
        mm.ind(1'b1, ADDR_PIN_POLARITY, 8'h1C, q);
        chk("polo", 8'h1C, fifo_pin_polarity);
        mm.ind(1'b1, ADDR_PIN_POLARITY, 8'hFF, q);
        mm.ind(1'b0, ADDR_PIN_POLARITY, 8'h00, q);
        chk("pol", POLARITY_RW_MASK, q);
        mm.ind(1'b1, ADDR_PIN_POLARITY, POLARITY_RESET, q);
        @(posedge clk) data_toggle_state <= 1'b1;
        mm.ind(1'b1, ADDR_TOGGLE_CTL, 8'hFF, q);
        chk("togo", TOGGLE_RW_MASK, data_toggle_control);
        mm.ind(1'b0, ADDR_TOGGLE_CTL, 8'h00, q);
        chk("tog", 8'hFF, q);
        mm.ind(1'b0, 16'h1234, 8'h00, q);
        chk("unmap", 8'h00, q);
        $display("test indirect done");
    endtask

    task automatic t_ctrl;
        mm.xfer(1'b1, IDX_CTRL_COUNT, 8'h05, q);
        for (int k = 0; k < 3; k++) mm.xfer(1'b1, IDX_CTRL_BUF, 8'hA0 + 8'(k), q);
        mm.xfer(1'b1, IDX_CTRL_COUNT, 8'h05, q);
        for (int k = 0; k < 3; k++) begin
            mm.xfer(1'b0, IDX_CTRL_BUF, 8'h00, q);
            chk("buf", 8'hA0 + 8'(k), q);
        end
        mm.xfer(1'b0, IDX_CTRL_COUNT, 8'h00, q);
        chk("cnt", 8'h05, q);
        for (int k = 3; k < CTRL_BUF_DEPTH; k++) mm.xfer(1'b0, IDX_CTRL_BUF, 8'h00, q);
        mm.xfer(1'b0, IDX_CTRL_BUF, 8'h00, q);
        chk("wrap", 8'hA0, q);
        @(posedge clk) control_request_in <= 64'h8877665544332211;
        control_request_new <= 1'b1;
        @(posedge clk) control_request_new <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            mm.xfer(1'b0, IDX_CTRL_REQ, 8'h00, q);
            chk("req", 8'h11 * 8'((k % 8) + 1), q);
        end
        mm.xfer(1'b1, IDX_CTRL_REQ, 8'h01, q);
        repeat (2) @(posedge clk);
        #1 chk("stall", 8'h01, stall_cnt);
        $display("test control done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_fifo();
        t_cfg();
        t_standby();
        t_ind();
        t_ctrl();
        wrap_up();
    end
endmodule

`default_nettype wire
